/* File: verilog/hubg_consts.svh */
// Purpose: constants for the host serial bit-rate generator and framer
// Assumes: 125 MHz system clock, 27.12 MHz crystal rate made by enable
// Notes: register offsets are word indices, byte address is index * 4
//
// How it works
// - Rate register: exponent in bits 7..5, base divisor in 4..0, both r/w.
// - Exponent zero: bit rate is crystal rate over (divisor + 1).
// - Exponent nonzero: crystal over (divisor + 33), over 2^(exponent - 1).
// - Every character: one start, eight data, one stop bit, no parity.
// - Rate register resets to 0x7A.
// - Settings map to standard rates, e.g. 0xEB, 0x7A, 0x15.
`ifndef HUBG_CONSTS_SVH
`define HUBG_CONSTS_SVH

`define HUBG_RATE_IDX 8'h3B
`define HUBG_STAT_IDX 8'h30
`define HUBG_RATE_RESET 8'h7A

`define HUBG_EXP_MSB 7
`define HUBG_EXP_LSB 5
`define HUBG_DIV_MSB 4
`define HUBG_DIV_LSB 0

`define HUBG_ADD_ZERO 13'h0001
`define HUBG_ADD_PRE 13'h0021

`define HUBG_CLK_KHZ 17'h1E848
`define HUBG_XTAL_KHZ 17'h069F0

`define HUBG_LAST_BIT 3'h7

`define HUBG_ST_TXBUSY 0
`define HUBG_ST_RXBUSY 1
`define HUBG_ST_FRERR 2
`define HUBG_ST_OVRUN 3
`define HUBG_ST_RXAVAIL 4
`define HUBG_ST_RATE_LSB 8

`endif

/* File: verilog/hubg_pkg.sv */
// Purpose: shared types and rate arithmetic
// Assumes: constants header is on the include path
// Notes: none
`include "hubg_consts.svh"

package hubg_pkg;

    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_START = 2'b01,
        FR_DATA = 2'b10,
        FR_STOP = 2'b11
    } hubg_frame_t;

    // Crystal ticks per bit; largest setting gives 4096
    function automatic logic [12:0] rateDivisor(input logic [7:0] rate);
        logic [2:0] ex;
        logic [12:0] base;
        ex = rate[`HUBG_EXP_MSB:`HUBG_EXP_LSB];
        base = {8'h00, rate[`HUBG_DIV_MSB:`HUBG_DIV_LSB]};
        if (ex == 3'h0)
            rateDivisor = base + `HUBG_ADD_ZERO;
        else
            rateDivisor = (base + `HUBG_ADD_PRE) << (ex - 3'h1);
    endfunction

    function automatic logic [11:0] regAddr(input logic [7:0] idx);
        regAddr = {2'h0, idx, 2'h0};
    endfunction

endpackage

/* File: verilog/hubg_xtal_tick.sv */
// Purpose: one-cycle enable at the crystal rate from the system clock
// Assumes: CLK_KHZ above XTAL_KHZ
// Notes: phase jitter is one system clock, well inside a bit
`timescale 1ns/1ns
`include "hubg_consts.svh"

module hubg_xtal_tick #(
    parameter logic [16:0] CLK_KHZ = `HUBG_CLK_KHZ,
    parameter logic [16:0] XTAL_KHZ = `HUBG_XTAL_KHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);

    typedef struct packed {
        logic [16:0] acc;
        logic tick;
    } hubg_xt_t;

    hubg_xt_t st_r;
    hubg_xt_t st_nxt;

    always_comb
    begin
        logic [17:0] sum;
        sum = {1'b0, st_r.acc} + {1'b0, XTAL_KHZ};
        st_nxt = st_r;
        if (sum >= {1'b0, CLK_KHZ})
        begin
            st_nxt.acc = 17'(sum - {1'b0, CLK_KHZ});
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.acc = sum[16:0];
            st_nxt.tick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;

endmodule // hubg_xtal_tick

/* File: verilog/hubg_fifo2.sv */
// Purpose: small shift buffer, head entry drives the outputs directly
// Assumes: DEPTH of at least 2
// Notes: inRdy is registered, so it reopens one cycle after a pop
`timescale 1ns/1ns

module hubg_fifo2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] inData,
    input wire logic inVal,
    output logic inRdy,
    output logic [W-1:0] outData,
    output logic outVal,
    input wire logic outRdy
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [DEPTH-1:0] vld;
        logic inRdy;
    } hubg_fifo_t;

    localparam hubg_fifo_t RST_C = '{mem: '0, vld: '0, inRdy: 1'b1};

    hubg_fifo_t st_r;
    hubg_fifo_t st_nxt;

    always_comb
    begin
        logic placed;
        placed = 1'b0;
        st_nxt = st_r;
        if (outRdy && st_r.vld[0])
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                st_nxt.mem[i] = st_r.mem[i+1];
                st_nxt.vld[i] = st_r.vld[i+1];
            end
            st_nxt.vld[DEPTH-1] = 1'b0;
        end
        if (inVal && st_r.inRdy)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (!placed && !st_nxt.vld[i])
                begin
                    st_nxt.mem[i] = inData;
                    st_nxt.vld[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
        st_nxt.inRdy = !st_nxt.vld[DEPTH-1];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= RST_C;
        else
            st_r <= st_nxt;
    end

    assign inRdy = st_r.inRdy;
    assign outData = st_r.mem[0];
    assign outVal = st_r.vld[0];

endmodule // hubg_fifo2

/* File: verilog/hubg_uart.sv */
// Purpose: host serial link with programmable bit rate and APB registers
// Assumes: host keeps the bit rate at or below 1228.8 kbit/s
// Notes: received characters pass a two-entry buffer to the user side
`timescale 1ns/1ns
`include "hubg_consts.svh"

module hubg_uart #(
    parameter int RX_DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic serialRx,
    output logic serialTx
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] regRate;
        logic [7:0] activeRate;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        hubg_pkg::hubg_frame_t txState;
        logic [7:0] txShift;
        logic [2:0] txBit;
        logic [12:0] txCnt;
        logic txLine;
        logic txReady;
        logic [2:0] rxSync;
        logic rxLevel;
        hubg_pkg::hubg_frame_t rxState;
        logic [7:0] rxShift;
        logic [2:0] rxBit;
        logic [12:0] rxCnt;
        logic pushVal;
        logic [7:0] pushData;
        logic frameErr;
        logic overrun;
    } hubg_uart_t;

    localparam hubg_uart_t RST_C = '{
        regRate: `HUBG_RATE_RESET,
        activeRate: `HUBG_RATE_RESET,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0,
        txState: hubg_pkg::FR_IDLE,
        txShift: 8'h00,
        txBit: 3'h0,
        txCnt: 13'h0000,
        txLine: 1'b1,
        txReady: 1'b1,
        rxSync: 3'h7,
        rxLevel: 1'b1,
        rxState: hubg_pkg::FR_IDLE,
        rxShift: 8'h00,
        rxBit: 3'h0,
        rxCnt: 13'h0000,
        pushVal: 1'b0,
        pushData: 8'h00,
        frameErr: 1'b0,
        overrun: 1'b0
    };

    hubg_uart_t st_r;
    hubg_uart_t st_nxt;
    logic xtalTick;
    logic fifoInRdy;

    ////////////////////////////////////////////////////////////////////////
    // Crystal-rate enable and receive buffer

    hubg_xtal_tick u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(xtalTick)
    );

    hubg_fifo2 #(
        .W(8),
        .DEPTH(RX_DEPTH)
    ) u_rxbuf (
        .clk(clk),
        .rst_n(rst_n),
        .inData(st_r.pushData),
        .inVal(st_r.pushVal),
        .inRdy(fifoInRdy),
        .outData(rxData),
        .outVal(rxValid),
        .outRdy(rxReady)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [12:0] div;
        logic hitRate;
        logic hitStat;
        logic txAccept;
        logic rxStart;
        logic [31:0] stat;
        div = hubg_pkg::rateDivisor(st_r.activeRate);
        hitRate = paddr == hubg_pkg::regAddr(`HUBG_RATE_IDX);
        hitStat = paddr == hubg_pkg::regAddr(`HUBG_STAT_IDX);
        txAccept = 1'b0;
        rxStart = 1'b0;
        stat = 32'h0000_0000;
        stat[`HUBG_ST_TXBUSY] = st_r.txState != hubg_pkg::FR_IDLE;
        stat[`HUBG_ST_RXBUSY] = st_r.rxState != hubg_pkg::FR_IDLE;
        stat[`HUBG_ST_FRERR] = st_r.frameErr;
        stat[`HUBG_ST_OVRUN] = st_r.overrun;
        stat[`HUBG_ST_RXAVAIL] = rxValid;
        stat[`HUBG_ST_RATE_LSB+7:`HUBG_ST_RATE_LSB] = st_r.activeRate;
        st_nxt = st_r;
        st_nxt.pushVal = 1'b0;

        // Bus: answer one cycle into the access phase
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (psel && penable && !st_r.pready)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !(hitRate || hitStat);
            if (hitRate)
                st_nxt.prdata = {24'h000000, st_r.regRate};
            else if (hitStat)
                st_nxt.prdata = stat;
            else
                st_nxt.prdata = 32'h0000_0000;
        end
        if (psel && penable && st_r.pready && pwrite)
        begin
            if (hitRate)
                st_nxt.regRate = pwdata[7:0];
            if (hitStat)
            begin
                // Write one to clear; a same-cycle event sets again below
                if (pwdata[`HUBG_ST_FRERR])
                    st_nxt.frameErr = 1'b0;
                if (pwdata[`HUBG_ST_OVRUN])
                    st_nxt.overrun = 1'b0;
            end
        end

        // Pin: change counts once stages two and three agree
        st_nxt.rxSync = {st_r.rxSync[1:0], serialRx};
        if (st_r.rxSync[1] == st_r.rxSync[2])
            st_nxt.rxLevel = st_r.rxSync[2];

        ////////////////////////////////////////////////////////////////////
        // Transmitter

        unique case (st_r.txState)
            hubg_pkg::FR_IDLE:
            begin
                if (txValid && st_r.txReady)
                begin
                    txAccept = 1'b1;
                    st_nxt.txShift = txData;
                    st_nxt.txLine = 1'b0;
                    st_nxt.txReady = 1'b0;
                    st_nxt.txCnt = div - 13'h0001;
                    st_nxt.txState = hubg_pkg::FR_START;
                end
            end
            hubg_pkg::FR_START:
            begin
                if (xtalTick && st_r.txCnt == 13'h0000)
                begin
                    st_nxt.txLine = st_r.txShift[0];
                    st_nxt.txBit = 3'h0;
                    st_nxt.txCnt = div - 13'h0001;
                    st_nxt.txState = hubg_pkg::FR_DATA;
                end
                else if (xtalTick)
                    st_nxt.txCnt = st_r.txCnt - 13'h0001;
            end
            hubg_pkg::FR_DATA:
            begin
                if (xtalTick && st_r.txCnt == 13'h0000)
                begin
                    st_nxt.txCnt = div - 13'h0001;
                    if (st_r.txBit == `HUBG_LAST_BIT)
                    begin
                        st_nxt.txLine = 1'b1;
                        st_nxt.txState = hubg_pkg::FR_STOP;
                    end
                    else
                    begin
                        st_nxt.txShift = {1'b0, st_r.txShift[7:1]};
                        st_nxt.txLine = st_r.txShift[1];
                        st_nxt.txBit = st_r.txBit + 3'h1;
                    end
                end
                else if (xtalTick)
                    st_nxt.txCnt = st_r.txCnt - 13'h0001;
            end
            hubg_pkg::FR_STOP:
            begin
                if (xtalTick && st_r.txCnt == 13'h0000)
                begin
                    st_nxt.txReady = 1'b1;
                    st_nxt.txState = hubg_pkg::FR_IDLE;
                end
                else if (xtalTick)
                    st_nxt.txCnt = st_r.txCnt - 13'h0001;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // Receiver, samples at mid-bit

        unique case (st_r.rxState)
            hubg_pkg::FR_IDLE:
            begin
                if (!st_r.rxLevel)
                begin
                    rxStart = 1'b1;
                    st_nxt.rxCnt = div >> 1;
                    st_nxt.rxState = hubg_pkg::FR_START;
                end
            end
            hubg_pkg::FR_START:
            begin
                if (xtalTick && st_r.rxCnt == 13'h0000)
                begin
                    // Glitch shorter than half a bit is dropped
                    st_nxt.rxState = st_r.rxLevel ? hubg_pkg::FR_IDLE
                                                  : hubg_pkg::FR_DATA;
                    st_nxt.rxBit = 3'h0;
                    st_nxt.rxCnt = div - 13'h0001;
                end
                else if (xtalTick)
                    st_nxt.rxCnt = st_r.rxCnt - 13'h0001;
            end
            hubg_pkg::FR_DATA:
            begin
                if (xtalTick && st_r.rxCnt == 13'h0000)
                begin
                    st_nxt.rxShift = {st_r.rxLevel, st_r.rxShift[7:1]};
                    st_nxt.rxCnt = div - 13'h0001;
                    st_nxt.rxBit = st_r.rxBit + 3'h1;
                    if (st_r.rxBit == `HUBG_LAST_BIT)
                        st_nxt.rxState = hubg_pkg::FR_STOP;
                end
                else if (xtalTick)
                    st_nxt.rxCnt = st_r.rxCnt - 13'h0001;
            end
            hubg_pkg::FR_STOP:
            begin
                if (xtalTick && st_r.rxCnt == 13'h0000)
                begin
                    st_nxt.rxState = hubg_pkg::FR_IDLE;
                    if (!st_r.rxLevel)
                        st_nxt.frameErr = 1'b1;
                    else if (fifoInRdy)
                    begin
                        st_nxt.pushVal = 1'b1;
                        st_nxt.pushData = st_r.rxShift;
                    end
                    else
                        st_nxt.overrun = 1'b1;
                end
                else if (xtalTick)
                    st_nxt.rxCnt = st_r.rxCnt - 13'h0001;
            end
        endcase

        // Rate swaps only with both directions idle
        if (st_r.txState == hubg_pkg::FR_IDLE && !txAccept
            && st_r.rxState == hubg_pkg::FR_IDLE && !rxStart)
            st_nxt.activeRate = st_r.regRate;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= RST_C;
        else
            st_r <= st_nxt;
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign txReady = st_r.txReady;
    assign serialTx = st_r.txLine;

endmodule // hubg_uart

/* File: tb/hubg_uart_checker.sv */
// Purpose: port assertions for the serial rate block
// Assumes: one clock, async active-low reset
// Notes: bound to every hubg_uart instance
`timescale 1ns/1ns

module hubg_uart_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic serialRx,
    input wire logic serialTx
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    AST_ONE_WAIT: assert property (psel && penable && !pready
        |=> pready)
        else $error("pready late");
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_ZERO: assert property (pslverr
        |-> pready && prdata == 32'h0)
        else $error("bad error response");
    AST_RATE_RD: assert property (pready && !pwrite
        && paddr == 12'h0EC |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("rate read upper bits set");
    AST_START: assert property (txValid && txReady
        |=> !serialTx && !txReady)
        else $error("no start bit after accept");
    // Fastest legal rate still gives about 100 clocks a bit
    AST_START_LEN: assert property ($fell(serialTx)
        |-> !serialTx [*8])
        else $error("start bit too short");
    AST_IDLE_HIGH: assert property (txReady |-> serialTx)
        else $error("line low while idle");
    AST_RX_HOLD: assert property (rxValid && !rxReady
        |=> rxValid && $stable(rxData))
        else $error("received word lost in stall");
endmodule // hubg_uart_checker

bind hubg_uart hubg_uart_checker u_hubg_uart_checker (.clk(clk),
    .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .serialRx(serialRx), .serialTx(serialTx));

/* File: tb/hubg_host_model.sv */
// Purpose: host side of the serial link
// Assumes: bitClk set by the bench to the programmed rate
// Notes: decodes by fixed mid-bit sampling, no resync
`timescale 1ns/1ns

module hubg_host_model (
    input wire logic clk,
    input wire logic serialTx,
    output logic serialRx
);
    real bitClk = 236 * 125.0 / 27.12;
    int lowLen = 0;
    int frames = 0;
    logic [7:0] got = 8'h00;
    logic stopOk = 1'b0;
    initial serialRx = 1'b1;
    ////////////////////////////////////////////////////////////
    // Start, eight data LSB first, stop, then one idle bit
    task sendByte(input logic [7:0] b, input logic stp);
        logic [10:0] f;
        int n;
        f = {1'b1, stp, b, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            serialRx <= f[i];
            n = $rtoi((i + 1) * bitClk) - $rtoi(i * bitClk);
            repeat (n) @(posedge clk);
        end
    endtask

    always
    begin
        @(negedge serialTx);
        lowLen = 0;
        for (int c = 1; c <= $rtoi(9.5 * bitClk); c++)
        begin
            @(negedge clk);
            if (serialTx && lowLen == 0)
                lowLen = c;
            for (int i = 0; i < 8; i++)
                if (c == $rtoi((i + 1.5) * bitClk))
                    got[i] = serialTx;
            stopOk = serialTx;
        end
        frames++;
    end
endmodule // hubg_host_model

/* File: tb/hubg_uart_tb.sv */
// Purpose: self-checking bench for the serial rate block
// Assumes: host model on the serial pins
// Notes: bit times checked within a few clocks of crystal jitter
`timescale 1ns/1ns
`include "hubg_consts.svh"

module hubg_uart_tb;
    localparam logic [11:0] RATE_A = {2'h0, `HUBG_RATE_IDX, 2'h0};
    localparam logic [11:0] STAT_A = {2'h0, `HUBG_STAT_IDX, 2'h0};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] txData = 8'h00;
    logic txValid = 1'b0;
    logic txReady;
    logic [7:0] rxData;
    logic rxValid;
    logic rxReady = 1'b0;
    logic serialRx;
    logic serialTx;
    logic [31:0] q;
    logic e;
    int f0;
    int failures = 0;
    int totalChecks = 0;
    logic [7:0] rates [3] = '{8'h15, 8'h3A, 8'h7A};
    logic [7:0] rxv [3] = '{8'h5A, 8'hC3, 8'h81};

    always #4 clk = ~clk;

    hubg_uart u_hubg_uart (.clk(clk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txData(txData), .txValid(txValid), .txReady(txReady),
        .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
        .serialRx(serialRx), .serialTx(serialTx));
    hubg_host_model u_hubg_host_model (.clk(clk), .serialTx(serialTx),
        .serialRx(serialRx));
    ////////////////////////////////////////////////////////////
    task end_sim;
        if (failures == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task tmo;
        failures++;
        $display("CHECK FAILED %0t timeout", $time);
        end_sim();
    endtask

    task chk(input logic [31:0] s, input logic [31:0] x);
        totalChecks++;
        if (s !== x)
        begin
            failures++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, x);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 50)
                tmo();
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Crystal ticks a bit, in system clocks
    function automatic real clks(input logic [7:0] r);
        int d;
        if (r[7:5] == 3'h0)
            d = r[4:0] + 1;
        else
            d = (r[4:0] + 33) << (r[7:5] - 1);
        return d * 125.0 / 27.12;
    endfunction

    // Start bit may lose one crystal tick of phase; host counts one late
    function automatic logic near(input logic [7:0] r);
        real x;
        x = 9 * clks(r);
        return u_hubg_host_model.lowLen > x - 5.5
            && u_hubg_host_model.lowLen < x + 2.5;
    endfunction

    task txFrame(input logic [7:0] b);
        f0 = u_hubg_host_model.frames;
        @(posedge clk);
        for (int n = 0; txReady !== 1'b1; n++)
        begin
            if (n > 30000)
                tmo();
            @(posedge clk);
        end
        txData <= b;
        txValid <= 1'b1;
        @(posedge clk);
        txValid <= 1'b0;
    endtask

    // Also waits out the stop bit so the line is idle
    task waitFrame;
        for (int n = 0; u_hubg_host_model.frames == f0 || !txReady; n++)
        begin
            if (n > 60000)
                tmo();
            @(posedge clk);
        end
    endtask

    task rxPop(input logic [7:0] x);
        // Let a pop from the previous call settle first
        @(posedge clk);
        for (int n = 0; rxValid !== 1'b1; n++)
        begin
            if (n > 5000)
                tmo();
            @(posedge clk);
        end
        chk({24'h0, rxData}, {24'h0, x});
        rxReady <= 1'b1;
        @(posedge clk);
        rxReady <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, RATE_A, 32'h0);
        chk(q, 32'h7A);
        apb(1'b0, STAT_A, 32'h0);
        chk(q, 32'h7A00);
        apb(1'b0, 12'h000, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, RATE_A, 32'hFFFFFF15);
        apb(1'b0, RATE_A, 32'h0);
        chk(q, 32'h15);
        foreach (rates[i])
        begin
            apb(1'b1, RATE_A, {24'h0, rates[i]});
            u_hubg_host_model.bitClk = clks(rates[i]);
            apb(1'b0, STAT_A, 32'h0);
            chk(q, {16'h0, rates[i], 8'h0});
            txFrame(8'h00);
            waitFrame();
            chk({31'h0, near(rates[i])}, 32'h1);
            txFrame(8'hA5);
            waitFrame();
            chk({24'h0, u_hubg_host_model.got}, 32'hA5);
            chk({31'h0, u_hubg_host_model.stopOk}, 32'h1);
        end
        apb(1'b1, RATE_A, 32'h15);
        u_hubg_host_model.bitClk = clks(8'h15);
        txFrame(8'h00);
        apb(1'b1, RATE_A, 32'h3A);
        apb(1'b0, STAT_A, 32'h0);
        chk(q & 32'hFF00, 32'h1500);
        waitFrame();
        chk({31'h0, near(8'h15)}, 32'h1);
        apb(1'b0, STAT_A, 32'h0);
        chk(q, 32'h3A00);
        apb(1'b1, RATE_A, 32'h15);
        // Receiver stalled: third word must overrun
        foreach (rxv[i])
            u_hubg_host_model.sendByte(rxv[i], 1'b1);
        repeat (20) @(posedge clk);
        apb(1'b0, STAT_A, 32'h0);
        chk(q, 32'h1518);
        rxPop(rxv[0]);
        rxPop(rxv[1]);
        apb(1'b1, STAT_A, 32'h8);
        apb(1'b0, STAT_A, 32'h0);
        chk(q, 32'h1500);
        u_hubg_host_model.sendByte(8'h11, 1'b0);
        repeat (200) @(posedge clk);
        apb(1'b0, STAT_A, 32'h0);
        chk(q, 32'h1504);
        end_sim();
    end
endmodule // hubg_uart_tb
